//--- rtl/pem_manager.sv
// Error aggregation manager with register port and sticky master flag.
// Contract
// - A clear happens only on a zero-to-one change of the clear bit.
// - The memory parity mask register resets to 0x0003.
// - Parity mask bits 11 to 8 gate banks 3 to 0 of the second data memory.
// - Parity mask bits 7 to 4 gate banks 3 to 0 of the first data memory.
// - Parity mask bits 3 and 2 gate the second and first program memory.
// - Parity mask bits 1 and 0 gate converters one and zero, reset to one.
// - Software mask bit 0 suppresses software errors when set, reset zero.
// - Watchdog mask bit 0 suppresses watchdog errors when set, reset zero.
// - Stack mask bit 0 suppresses stack errors when set, reset zero.
// - Any unmasked error sets the single master error flag, except in a cycle where a clear fires.
// - The master flag stays set until the clear sequence is performed.
// - The source record keeps only the first reported error set.
`timescale 1ns/1ps
module pem_manager (
    input wire logic core_clk,
    input wire logic reset,
    input wire logic [15:0] reg_addr,
    input wire logic [15:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [15:0] reg_rdata,
    input wire logic [11:0] parity_err,
    input wire logic software_err,
    input wire logic loop_err,
    input wire logic stack_err,
    input wire logic watchdog_err,
    output logic error_flag,
    output logic [15:0] error_source,
    output logic irq
);

    // ------------------------------------------------------------------
    // Input capture
    // ------------------------------------------------------------------
    pem_pkg::pem_bus_req_type req;
    pem_pkg::pem_err_type err_raw;
    pem_pkg::pem_err_type err_s1_q;
    pem_pkg::pem_err_type err_s2_q;
    pem_pkg::pem_err_type err_s1_d;
    pem_pkg::pem_err_type err_s2_d;

    assign req = '{addr: reg_addr, wdata: reg_wdata, wr: reg_wr, rd: reg_rd};
    assign err_raw = '{software: software_err, loop: loop_err,
                       stack: stack_err, watchdog: watchdog_err,
                       parity: parity_err};

    always_comb begin
        err_s1_d = err_raw;
        err_s2_d = err_s1_q;
    end

    always_ff @(posedge core_clk) begin
        if (reset) begin
            err_s1_q <= '0;
            err_s2_q <= '0;
        end else begin
            err_s1_q <= err_s1_d;
            err_s2_q <= err_s2_d;
        end
    end

    // ------------------------------------------------------------------
    // Configuration registers
    // ------------------------------------------------------------------
    logic clear_bit_q;
    logic clear_bit_d;
    logic [11:0] parity_mask_q;
    logic [11:0] parity_mask_d;
    logic software_mask_q;
    logic software_mask_d;
    logic watchdog_mask_q;
    logic watchdog_mask_d;
    logic stack_mask_q;
    logic stack_mask_d;
    logic loop_mask_q;
    logic loop_mask_d;
    logic [1:0] irq_mask_q;
    logic [1:0] irq_mask_d;
    logic clear_pulse;

    always_comb begin
        clear_bit_d = clear_bit_q;
        parity_mask_d = parity_mask_q;
        software_mask_d = software_mask_q;
        watchdog_mask_d = watchdog_mask_q;
        stack_mask_d = stack_mask_q;
        loop_mask_d = loop_mask_q;
        irq_mask_d = irq_mask_q;
        if (req.wr) begin
            unique case (req.addr)
                pem_pkg::ADDR_CLEAR: begin
                    clear_bit_d = req.wdata[0];
                end
                pem_pkg::ADDR_PARITY_MASK: begin
                    parity_mask_d = req.wdata[11:0];
                end
                pem_pkg::ADDR_SOFTWARE_MASK: begin
                    software_mask_d = req.wdata[0];
                end
                pem_pkg::ADDR_WATCHDOG_MASK: begin
                    watchdog_mask_d = req.wdata[0];
                end
                pem_pkg::ADDR_STACK_MASK: begin
                    stack_mask_d = req.wdata[0];
                end
                pem_pkg::ADDR_LOOP_MASK: begin
                    loop_mask_d = req.wdata[0];
                end
                pem_pkg::ADDR_IRQ_MASK: begin
                    irq_mask_d = req.wdata[1:0];
                end
                default: begin
                end
            endcase
        end
    end

    always_ff @(posedge core_clk) begin
        if (reset) begin
            clear_bit_q <= 1'b0;
            parity_mask_q <= pem_pkg::RST_PARITY_MASK[11:0];
            software_mask_q <= 1'b0;
            watchdog_mask_q <= 1'b0;
            stack_mask_q <= 1'b0;
            loop_mask_q <= 1'b0;
            irq_mask_q <= 2'h0;
        end else begin
            clear_bit_q <= clear_bit_d;
            parity_mask_q <= parity_mask_d;
            software_mask_q <= software_mask_d;
            watchdog_mask_q <= watchdog_mask_d;
            stack_mask_q <= stack_mask_d;
            loop_mask_q <= loop_mask_d;
            irq_mask_q <= irq_mask_d;
        end
    end

    // A clear fires only when the stored bit rises from zero to one.
    assign clear_pulse = clear_bit_d & ~clear_bit_q;

    // ------------------------------------------------------------------
    // Error gating and capture
    // ------------------------------------------------------------------
    logic [15:0] reported;
    logic flag_q;
    logic flag_d;
    logic [15:0] source_q;
    logic [15:0] source_d;

    always_comb begin
        reported = 16'h0000;
        reported[11:0] = err_s2_q.parity & ~parity_mask_q;
        reported[pem_pkg::WATCHDOG_BIT] = err_s2_q.watchdog & ~watchdog_mask_q;
        reported[pem_pkg::STACK_BIT] = err_s2_q.stack & ~stack_mask_q;
        reported[pem_pkg::LOOP_BIT] = err_s2_q.loop & ~loop_mask_q;
        reported[pem_pkg::SOFTWARE_BIT] = err_s2_q.software & ~software_mask_q;
    end

    always_comb begin
        flag_d = flag_q;
        source_d = source_q;
        if (clear_pulse) begin
            flag_d = 1'b0;
            source_d = 16'h0000;
        end else if (|reported) begin
            flag_d = 1'b1;
            if (!flag_q) begin
                source_d = reported;
            end
        end
    end

    always_ff @(posedge core_clk) begin
        if (reset) begin
            flag_q <= 1'b0;
            source_q <= pem_pkg::RST_ZERO;
        end else begin
            flag_q <= flag_d;
            source_q <= source_d;
        end
    end

    // ------------------------------------------------------------------
    // Interrupt status
    // ------------------------------------------------------------------
    logic [1:0] irq_stat_q;
    logic [1:0] irq_stat_d;
    logic [1:0] irq_event;
    logic irq_q;
    logic irq_d;

    always_comb begin
        irq_event = 2'h0;
        irq_event[pem_pkg::IRQ_FLAG_BIT] = flag_d & ~flag_q;
        irq_event[pem_pkg::IRQ_MASKED_BIT] =
            |({err_s2_q.software, err_s2_q.loop, err_s2_q.stack,
               err_s2_q.watchdog, err_s2_q.parity} & ~reported);
        irq_stat_d = irq_stat_q;
        if (req.rd && req.addr == pem_pkg::ADDR_IRQ_STATUS) begin
            irq_stat_d = 2'h0;
        end
        irq_stat_d = irq_stat_d | irq_event;
        irq_d = |(irq_stat_d & ~irq_mask_d);
    end

    always_ff @(posedge core_clk) begin
        if (reset) begin
            irq_stat_q <= 2'h0;
            irq_q <= 1'b0;
        end else begin
            irq_stat_q <= irq_stat_d;
            irq_q <= irq_d;
        end
    end

    // ------------------------------------------------------------------
    // Read port
    // ------------------------------------------------------------------
    logic [15:0] rdata_q;
    logic [15:0] rdata_d;

    always_comb begin
        rdata_d = 16'h0000;
        if (req.rd) begin
            unique case (req.addr)
                pem_pkg::ADDR_CLEAR: rdata_d = {15'h0000, clear_bit_q};
                pem_pkg::ADDR_PARITY_MASK: rdata_d = {4'h0, parity_mask_q};
                pem_pkg::ADDR_SOFTWARE_MASK:
                    rdata_d = {15'h0000, software_mask_q};
                pem_pkg::ADDR_WATCHDOG_MASK:
                    rdata_d = {15'h0000, watchdog_mask_q};
                pem_pkg::ADDR_STACK_MASK: rdata_d = {15'h0000, stack_mask_q};
                pem_pkg::ADDR_LOOP_MASK: rdata_d = {15'h0000, loop_mask_q};
                pem_pkg::ADDR_FLAG: rdata_d = {15'h0000, flag_q};
                pem_pkg::ADDR_SOURCE: rdata_d = source_q;
                pem_pkg::ADDR_IRQ_STATUS: rdata_d = {14'h0000, irq_stat_q};
                pem_pkg::ADDR_IRQ_MASK: rdata_d = {14'h0000, irq_mask_q};
                default: rdata_d = 16'h0000;
            endcase
        end
    end

    always_ff @(posedge core_clk) begin
        if (reset) begin
            rdata_q <= 16'h0000;
        end else begin
            rdata_q <= rdata_d;
        end
    end

    assign reg_rdata = rdata_q;
    assign error_flag = flag_q;
    assign error_source = source_q;
    assign irq = irq_q;

endmodule

//--- rtl/pem_pkg.sv
// Package of constants and types for the error aggregation manager.
package pem_pkg;

    // ------------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------------
    localparam logic [15:0] ADDR_CLEAR = 16'hf421;
    localparam logic [15:0] ADDR_PARITY_MASK = 16'hf422;
    localparam logic [15:0] ADDR_SOFTWARE_MASK = 16'hf423;
    localparam logic [15:0] ADDR_WATCHDOG_MASK = 16'hf424;
    localparam logic [15:0] ADDR_STACK_MASK = 16'hf425;
    localparam logic [15:0] ADDR_LOOP_MASK = 16'hf426;
    localparam logic [15:0] ADDR_FLAG = 16'hf427;
    localparam logic [15:0] ADDR_SOURCE = 16'hf428;
    localparam logic [15:0] ADDR_IRQ_STATUS = 16'hf429;
    localparam logic [15:0] ADDR_IRQ_MASK = 16'hf42a;

    // ------------------------------------------------------------------
    // Reset values and field layout
    // ------------------------------------------------------------------
    localparam logic [15:0] RST_PARITY_MASK = 16'h0003;
    localparam logic [15:0] RST_ZERO = 16'h0000;
    localparam logic [11:0] PARITY_FIELD_MASK = 12'hfff;
    localparam int PARITY_BITS = 12;
    localparam int SOFTWARE_BIT = 15;
    localparam int LOOP_BIT = 14;
    localparam int STACK_BIT = 13;
    localparam int WATCHDOG_BIT = 12;
    localparam int IRQ_FLAG_BIT = 0;
    localparam int IRQ_MASKED_BIT = 1;
    localparam int IRQ_BITS = 2;

    // ------------------------------------------------------------------
    // Carrier types
    // ------------------------------------------------------------------
    typedef struct packed {
        logic [15:0] addr;
        logic [15:0] wdata;
        logic wr;
        logic rd;
    } pem_bus_req_type;

    typedef struct packed {
        logic software;
        logic loop;
        logic stack;
        logic watchdog;
        logic [11:0] parity;
    } pem_err_type;

endpackage

//--- dv/pem_manager_props.sv
// Assertion checker for the error aggregation manager.
`timescale 1ns/1ps
module pem_manager_props (
    input wire logic core_clk,
    input wire logic reset,
    input wire logic [15:0] reg_addr,
    input wire logic [15:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [15:0] reg_rdata,
    input wire logic [11:0] parity_err,
    input wire logic software_err,
    input wire logic loop_err,
    input wire logic stack_err,
    input wire logic watchdog_err,
    input wire logic error_flag,
    input wire logic [15:0] error_source,
    input wire logic irq
);
    logic [15:0] pm_q, sm_q, wm_q, km_q, cl_q, lm_q;
    logic hit;
    // -------------------------------------------------------------------
    // Shadow copies of the error mask and clear registers.
    // -------------------------------------------------------------------
    always_ff @(posedge core_clk) begin
        if (reset) begin
            pm_q <= 16'h0003;
            sm_q <= 16'h0000;
            wm_q <= 16'h0000;
            km_q <= 16'h0000;
            cl_q <= 16'h0000;
            lm_q <= 16'h0000;
        end else if (reg_wr) begin
            case (reg_addr)
                pem_pkg::ADDR_PARITY_MASK: pm_q <= reg_wdata;
                pem_pkg::ADDR_SOFTWARE_MASK: sm_q <= reg_wdata;
                pem_pkg::ADDR_WATCHDOG_MASK: wm_q <= reg_wdata;
                pem_pkg::ADDR_STACK_MASK: km_q <= reg_wdata;
                pem_pkg::ADDR_CLEAR: cl_q <= reg_wdata;
                pem_pkg::ADDR_LOOP_MASK: lm_q <= reg_wdata;
                default: ;
            endcase
        end
    end
    assign hit = (|(parity_err & ~pm_q[11:0])) | (software_err & ~sm_q[0])
        | (stack_err & ~km_q[0]) | (watchdog_err & ~wm_q[0])
        | (loop_err & ~lm_q[0]);
    // -------------------------------------------------------------------
    // Properties.
    // -------------------------------------------------------------------
    default clocking @(posedge core_clk); endclocking
    default disable iff (reset);
    sequence s_clear;
        reg_wr && reg_addr == pem_pkg::ADDR_CLEAR && reg_wdata[0] && !cl_q[0];
    endsequence
    sequence s_stack_run;
        (stack_err && !km_q[0] && !reg_wr)[*5];
    endsequence
    property p_clear;
        s_clear |=> !error_flag && error_source == 16'h0000;
    endproperty
    property p_hold;
        error_flag && !reg_wr |=> error_flag;
    endproperty
    property p_frozen;
        error_flag && !reg_wr |=> $stable(error_source);
    endproperty
    property p_pair;
        (error_source != 16'h0000) == error_flag;
    endproperty
    property p_stack;
        s_stack_run |-> error_flag;
    endproperty
    property p_cause;
        $rose(error_flag) |-> $past(hit, 2) || $past(hit, 3) || $past(hit, 4);
    endproperty
    property p_idle;
        !reg_rd |=> reg_rdata == 16'h0000;
    endproperty
    property p_rd_mask;
        reg_rd && reg_addr == pem_pkg::ADDR_PARITY_MASK
            |=> reg_rdata == ($past(pm_q) & 16'h0fff);
    endproperty
    property p_no_clear;
        reg_wr && reg_addr == pem_pkg::ADDR_CLEAR && error_flag
            && !(reg_wdata[0] && !cl_q[0]) |=> error_flag;
    endproperty
    a_clear: assert property (p_clear) else $error("clear missed");
    a_hold: assert property (p_hold) else $error("flag dropped");
    a_frozen: assert property (p_frozen) else $error("record moved");
    a_pair: assert property (p_pair) else $error("flag vs record");
    a_stack: assert property (p_stack) else $error("stack lost");
    a_cause: assert property (p_cause) else $error("flag no cause");
    a_idle: assert property (p_idle) else $error("rdata not zero");
    a_rd_mask: assert property (p_rd_mask) else $error("mask read");
    a_no_clear: assert property (p_no_clear) else $error("no edge");
endmodule
bind pem_manager pem_manager_props u_props (.core_clk(core_clk),
    .reset(reset), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .parity_err(parity_err), .software_err(software_err),
    .loop_err(loop_err), .stack_err(stack_err),
    .watchdog_err(watchdog_err), .error_flag(error_flag),
    .error_source(error_source), .irq(irq));

//--- dv/pem_manager_tb.sv
// Self-checking testbench for the error aggregation manager.
`timescale 1ns/1ps
module pem_manager_tb;
    logic core_clk, reset, reg_wr, reg_rd, error_flag, irq;
    logic software_err, loop_err, stack_err, watchdog_err;
    logic [15:0] reg_addr, reg_wdata, reg_rdata, error_source;
    logic [11:0] parity_err;
    int fails, checks;
    pem_manager uut (.core_clk(core_clk), .reset(reset),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_rdata(reg_rdata), .parity_err(parity_err),
        .software_err(software_err), .loop_err(loop_err),
        .stack_err(stack_err), .watchdog_err(watchdog_err),
        .error_flag(error_flag), .error_source(error_source), .irq(irq));
    // -------------------------------------------------------------------
    // Bus and error tasks.
    // -------------------------------------------------------------------
    task automatic chk(input string nm, input logic [15:0] e, g);
        checks++;
        if (g !== e) begin
            fails++;
            $display("CHECK FAILED %s exp %h got %h", nm, e, g);
        end
    endtask
    task automatic wr(input logic [15:0] a, d);
        @(posedge core_clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge core_clk);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(input logic [15:0] a, e);
        @(posedge core_clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge core_clk);
        reg_rd <= 1'b0;
        #1 chk("rdata", e, reg_rdata);
    endtask
    task automatic clr();
        wr(pem_pkg::ADDR_CLEAR, 16'h0001);
        wr(pem_pkg::ADDR_CLEAR, 16'h0000);
    endtask
    task automatic pulse(input logic [15:0] e, input int n);
        @(posedge core_clk);
        {software_err, loop_err, stack_err, watchdog_err, parity_err} <= e;
        repeat (n) @(posedge core_clk);
        {software_err, loop_err, stack_err, watchdog_err, parity_err} <= 0;
        repeat (5) @(posedge core_clk);
        #1;
    endtask
    task automatic close_out();
        $display("checks %0d fails %0d", checks, fails);
        if (fails == 0 && checks > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    // -------------------------------------------------------------------
    // Clock, watchdog and tests.
    // -------------------------------------------------------------------
    initial begin
        core_clk = 1'b0;
        forever #12.5 core_clk = ~core_clk;
    end
    initial begin
        repeat (6000) @(posedge core_clk);
        fails++;
        close_out();
    end
    initial begin
        {reset, reg_wr, reg_rd, reg_addr, reg_wdata} = {3'b100, 32'h0};
        {software_err, loop_err, stack_err, watchdog_err, parity_err} = 0;
        repeat (20) @(posedge core_clk);
        reset <= 1'b0;
        for (int i = 0; i < 5; i++) begin
            rd(pem_pkg::ADDR_CLEAR + 16'(i), (i == 1) ? 16'h0003 : 0);
        end
        rd(16'hf430, 16'h0000);
        wr(pem_pkg::ADDR_IRQ_MASK, 16'h0001);
        pulse(16'h2000, 1);
        chk("irq", 16'h0000, {15'h0000, irq});
        wr(pem_pkg::ADDR_IRQ_MASK, 16'h0000);
        repeat (2) @(posedge core_clk);
        #1 chk("irq", 16'h0001, {15'h0000, irq});
        rd(pem_pkg::ADDR_IRQ_STATUS, 16'h0001);
        repeat (2) @(posedge core_clk);
        #1 chk("irq", 16'h0000, {15'h0000, irq});
        wr(pem_pkg::ADDR_PARITY_MASK, 16'h0000);
        for (int m = 0; m < 2; m++) begin
            for (int i = 0; i < 16; i++) begin
                clr();
                pulse(16'h0001 << i, 5);
                chk("flag", m ? 0 : 1, {15'h0000, error_flag});
                chk("src", m ? 0 : 16'h0001 << i, error_source);
            end
            wr(pem_pkg::ADDR_PARITY_MASK, 16'hffff);
            for (int r = 1; r < 5; r++) begin
                wr(pem_pkg::ADDR_PARITY_MASK + 16'(r), 16'h0001);
            end
        end
        rd(pem_pkg::ADDR_IRQ_STATUS, 16'h0003);
        rd(pem_pkg::ADDR_PARITY_MASK, 16'h0fff);
        for (int r = 0; r < 5; r++) begin
            wr(pem_pkg::ADDR_PARITY_MASK + 16'(r), 16'h0000);
        end
        clr();
        pulse(16'h2000, 1);
        pulse(16'h1000, 1);
        chk("src", 16'h2000, error_source);
        wr(pem_pkg::ADDR_CLEAR, 16'h0000);
        rd(pem_pkg::ADDR_FLAG, 16'h0001);
        wr(pem_pkg::ADDR_CLEAR, 16'h0001);
        rd(pem_pkg::ADDR_FLAG, 16'h0000);
        pulse(16'h0001, 1);
        wr(pem_pkg::ADDR_CLEAR, 16'h0001);
        rd(pem_pkg::ADDR_FLAG, 16'h0001);
        clr();
        rd(pem_pkg::ADDR_FLAG, 16'h0001);
        clr();
        rd(pem_pkg::ADDR_FLAG, 16'h0000);
        pulse(16'hb00f, 1);
        chk("src", 16'hb00f, error_source);
        close_out();
    end
endmodule
